// ### chan_cfg_consts.svh
// Offsets, field positions, reset values and timing counts of the channel
// configuration block. Assumes byte-wide registers on an 8-bit offset.
`ifndef CHAN_CFG_CONSTS_SVH
`define CHAN_CFG_CONSTS_SVH

// ==========================================================================
// Register offsets
`define DEV_CTRL_OFS 8'h04
`define OP_CTRL_OFS 8'h05
`define MEM_QUAL_OFS 8'h29
`define DEV_QUAL_OFS 8'h31
`define RELOAD_QUAL_OFS 8'h39

// ==========================================================================
// Field positions
`define QUAL_PRIV_BIT 2
`define QUAL_WIDTH_BIT 1
`define QUAL_PROG_BIT 0
`define XRM_HI 7
`define XRM_LO 6
`define DKIND_HI 5
`define DKIND_LO 4
`define DPW_BIT 3
`define PLF_HI 1
`define PLF_LO 0
`define DIR_BIT 7
`define OPSIZE_HI 5
`define OPSIZE_LO 4
`define CHAIN_HI 3
`define CHAIN_LO 2
`define REQUEST_GENERATION_HI 1
`define REQUEST_GENERATION_LO 0

// ==========================================================================
// Reset values
`define DEV_CTRL_RST 8'h00
`define OP_CTRL_RST 8'h00
`define QUAL_RST 3'h0
`define JUMPER_RST 3'h0

// ==========================================================================
// Timing: the start pulse is an eighth of a controller clock, so it is
// stretched to the shortest pulse this clock can make.
`define START_PULSE_CYC 1

`endif

// ### chan_cfg_pkg.sv
// Types shared by the channel configuration block.
// Assumes the constants header is compiled alongside.
package chan_cfg_pkg;

	// ======================================================================
	// Encodings
	typedef enum logic [1:0] {XRM_BURST = 2'h0, XRM_RSVD = 2'h1,
		XRM_STEAL = 2'h2, XRM_STEAL_HOLD = 2'h3} req_mode_t;
	typedef enum logic [1:0] {PLF_STATUS = 2'h0, PLF_STATUS_IRQ = 2'h1,
		PLF_START_OUT = 2'h2, PLF_ABORT_IN = 2'h3} line_func_t;
	typedef enum logic [1:0] {OPS_BYTE = 2'h0, OPS_WORD = 2'h1,
		OPS_LONG = 2'h2, OPS_RSVD = 2'h3} op_size_t;
	typedef enum logic [1:0] {CHN_NONE = 2'h0, CHN_RSVD = 2'h1,
		CHN_ARRAY = 2'h2, CHN_LINKED = 2'h3} chain_t;
	typedef enum logic [1:0] {PTR_MEMORY = 2'h0, PTR_DEVICE = 2'h1,
		PTR_RELOAD = 2'h2, PTR_NONE = 2'h3} ptr_sel_t;
	typedef enum {ST_IDLE, ST_FETCH, ST_XFER} chan_state_t;

endpackage

// ### dma_channel_config_regs.sv
// Configuration registers of one DMA channel, the qualifier and address
// modifier outputs, the peripheral line, start sequencing and data FIFO.
// Assumes a byte-wide register port and a transfer engine that handshakes
// table fetches and transfer completion.
`timescale 1ns/1ps
`include "chan_cfg_consts.svh"

// ==========================================================================
// Three-stage input synchroniser; output moves when stages two and three
// agree, which filters a single-cycle glitch.
module sync3 #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= (s2 == s3) ? s3 : level;
		end
	end
endmodule // sync3

// ==========================================================================
// Flip-flop FIFO with valid/ready on both sides.
module data_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // data_fifo

// ==========================================================================
module dma_channel_config_regs (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [2:0] jumper_pins,
	input wire logic ptr_drive,
	input wire logic [1:0] ptr_sel,
	output logic [2:0] fc_out,
	output logic [5:0] am_code,
	output logic supervisor_cycle,
	output logic std24_cycle,
	output logic program_space,
	output logic [1:0] external_request_mode,
	output logic [1:0] device_kind_select,
	output logic device_port_width,
	output logic [1:0] peripheral_line_function,
	output logic xfer_dir_to_mem,
	output logic [1:0] operand_size,
	output logic [1:0] chain_mode,
	output logic [1:0] request_generation,
	output logic flyby_mode,
	input wire logic periph_in_n,
	output logic periph_out_n,
	output logic periph_oe_n,
	output logic peripheral_line_state,
	output logic periph_irq,
	output logic periph_abort,
	input wire logic ext_req_n,
	input wire logic start_req,
	output logic start_refused,
	output logic config_error,
	output logic fetch_req,
	input wire logic fetch_done,
	output logic xfer_active,
	input wire logic xfer_done,
	output logic operand_req,
	input wire logic dev_valid,
	output logic dev_ready,
	input wire logic [15:0] dev_data,
	output logic mem_valid,
	input wire logic mem_ready,
	output logic [15:0] mem_data
);
	// ======================================================================
	// Register storage
	logic [7:0] device_control;
	logic [7:0] operation_control;
	logic [2:0] memory_space_qualifier;
	logic [2:0] device_space_qualifier;
	logic [2:0] reload_space_qualifier;
	chan_cfg_pkg::chan_state_t state;
	chan_cfg_pkg::chan_state_t next_state;
	logic [2:0] jumpers;
	logic line_level_n;
	logic line_prev_n;
	logic line_active;
	logic ext_req_sync;
	logic first_done;
	logic [7:0] next_rdata;

	sync3 #(.W(5)) pin_sync (
		.clock(clock),
		.nrst(nrst),
		.pin({jumper_pins, !periph_in_n, !ext_req_n}),
		.level({jumpers, line_active, ext_req_sync})
	);
	// Active-low pins are inverted ahead of the synchroniser so its reset
	// state matches their idle level; otherwise reset release would look
	// like a line fall and a pending external request.
	assign line_level_n = !line_active;

	// ======================================================================
	// Decode
	wire wr_dev = reg_we && (reg_addr == `DEV_CTRL_OFS);
	wire wr_op = reg_we && (reg_addr == `OP_CTRL_OFS);
	wire wr_mq = reg_we && (reg_addr == `MEM_QUAL_OFS);
	wire wr_dq = reg_we && (reg_addr == `DEV_QUAL_OFS);
	wire wr_rq = reg_we && (reg_addr == `RELOAD_QUAL_OFS);

	assign external_request_mode = device_control[`XRM_HI:`XRM_LO];
	assign device_kind_select = device_control[`DKIND_HI:`DKIND_LO];
	assign device_port_width = device_control[`DPW_BIT];
	assign peripheral_line_function = device_control[`PLF_HI:`PLF_LO];
	assign xfer_dir_to_mem = operation_control[`DIR_BIT];
	assign operand_size = operation_control[`OPSIZE_HI:`OPSIZE_LO];
	assign chain_mode = operation_control[`CHAIN_HI:`CHAIN_LO];
	assign request_generation = operation_control[`REQUEST_GENERATION_HI:`REQUEST_GENERATION_LO];
	// Both acknowledge-style kinds are addressed by acknowledge alone.
	assign flyby_mode = device_kind_select[1];

	// Reserved codes stop a start rather than run an undefined transfer.
	assign config_error =
		(external_request_mode == chan_cfg_pkg::XRM_RSVD) ||
		(operand_size == chan_cfg_pkg::OPS_RSVD) ||
		(chain_mode == chan_cfg_pkg::CHN_RSVD);

	wire start_ok = start_req && !config_error &&
		(state == chan_cfg_pkg::ST_IDLE);
	wire chained = (chain_mode != chan_cfg_pkg::CHN_NONE);

	// ======================================================================
	// Qualifier selection and address modifier
	wire [2:0] sel_qual =
		(ptr_sel == chan_cfg_pkg::PTR_MEMORY) ? memory_space_qualifier :
		(ptr_sel == chan_cfg_pkg::PTR_DEVICE) ? device_space_qualifier :
		(ptr_sel == chan_cfg_pkg::PTR_RELOAD) ? reload_space_qualifier :
		`QUAL_RST;
	assign am_code = {jumpers, fc_out};
	assign supervisor_cycle = fc_out[`QUAL_PRIV_BIT];
	assign std24_cycle = fc_out[`QUAL_WIDTH_BIT];
	assign program_space = fc_out[`QUAL_PROG_BIT];

	// ======================================================================
	// Register reads; qualifier don't-care bits read as zero.
	always_comb begin
		case (reg_addr)
			`DEV_CTRL_OFS: next_rdata = device_control;
			`OP_CTRL_OFS: next_rdata = operation_control;
			`MEM_QUAL_OFS: next_rdata = {5'h00, memory_space_qualifier};
			`DEV_QUAL_OFS: next_rdata = {5'h00, device_space_qualifier};
			`RELOAD_QUAL_OFS: next_rdata = {5'h00, reload_space_qualifier};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_re ? next_rdata : reg_rdata;
			reg_rvalid <= reg_re;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			device_control <= `DEV_CTRL_RST;
			operation_control <= `OP_CTRL_RST;
			memory_space_qualifier <= `QUAL_RST;
			device_space_qualifier <= `QUAL_RST;
			reload_space_qualifier <= `QUAL_RST;
		end else begin
			device_control <= wr_dev ? reg_wdata : device_control;
			operation_control <= wr_op ? reg_wdata : operation_control;
			memory_space_qualifier <= wr_mq ? reg_wdata[2:0] :
				memory_space_qualifier;
			device_space_qualifier <= wr_dq ? reg_wdata[2:0] :
				device_space_qualifier;
			reload_space_qualifier <= wr_rq ? reg_wdata[2:0] :
				reload_space_qualifier;
		end
	end

	// Qualifier is held while no pointer is driven.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fc_out <= `QUAL_RST;
		end else begin
			fc_out <= ptr_drive ? sel_qual : fc_out;
		end
	end

	// ======================================================================
	// Peripheral line
	wire line_fall = line_prev_n && !line_level_n;
	wire pl_status = (peripheral_line_function == chan_cfg_pkg::PLF_STATUS) ||
		(peripheral_line_function == chan_cfg_pkg::PLF_STATUS_IRQ);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			line_prev_n <= 1'b1;
			peripheral_line_state <= 1'b0;
			periph_irq <= 1'b0;
			periph_abort <= 1'b0;
			periph_out_n <= 1'b1;
			periph_oe_n <= 1'b1;
		end else begin
			line_prev_n <= line_level_n;
			peripheral_line_state <= pl_status ? line_level_n :
				peripheral_line_state;
			periph_irq <= line_fall && (peripheral_line_function ==
				chan_cfg_pkg::PLF_STATUS_IRQ);
			periph_abort <= line_fall && (peripheral_line_function ==
				chan_cfg_pkg::PLF_ABORT_IN);
			periph_out_n <= !(start_ok && (peripheral_line_function ==
				chan_cfg_pkg::PLF_START_OUT));
			periph_oe_n <= (peripheral_line_function !=
				chan_cfg_pkg::PLF_START_OUT);
		end
	end

	// ======================================================================
	// Start sequencing; a chained start fetches the block address first.
	always_comb begin
		next_state = state;
		case (state)
			chan_cfg_pkg::ST_IDLE: begin
				if (start_ok) begin
					next_state = chained ? chan_cfg_pkg::ST_FETCH :
						chan_cfg_pkg::ST_XFER;
				end
			end
			chan_cfg_pkg::ST_FETCH: begin
				if (periph_abort) begin
					next_state = chan_cfg_pkg::ST_IDLE;
				end else if (fetch_done) begin
					next_state = chan_cfg_pkg::ST_XFER;
				end
			end
			chan_cfg_pkg::ST_XFER: begin
				if (periph_abort || xfer_done) begin
					next_state = chan_cfg_pkg::ST_IDLE;
				end
			end
			default: next_state = chan_cfg_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= chan_cfg_pkg::ST_IDLE;
			start_refused <= 1'b0;
			first_done <= 1'b0;
		end else begin
			state <= next_state;
			start_refused <= start_req && config_error;
			first_done <= (state == chan_cfg_pkg::ST_XFER) &&
				(operand_req || first_done);
		end
	end

	assign fetch_req = (state == chan_cfg_pkg::ST_FETCH);
	assign xfer_active = (state == chan_cfg_pkg::ST_XFER);

	// Operand requests: external modes wait on the line; the mixed mode
	// issues the first one itself. Only the FIFO's room gates auto rates,
	// the global rate limit is applied by the transfer engine.
	wire ext_req = ext_req_sync;
	wire req_by_mode =
		(request_generation == 2'h2) ? ext_req :
		(request_generation == 2'h3) ? (!first_done || ext_req) :
		1'b1;
	assign operand_req = xfer_active && req_by_mode && dev_ready;

	// ======================================================================
	// Device-to-memory data buffer; a full buffer stalls the device side.
	wire fifo_in_ready;
	assign dev_ready = fifo_in_ready && xfer_active;
	data_fifo #(.WIDTH(16), .DEPTH(8)) xfer_fifo (
		.clock(clock),
		.nrst(nrst),
		.in_valid(dev_valid && xfer_active),
		.in_ready(fifo_in_ready),
		.in_data(dev_data),
		.out_valid(mem_valid),
		.out_ready(mem_ready),
		.out_data(mem_data)
	);

	// ======================================================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	qual_follows_ptr_a: assert property (
		ptr_drive && ptr_sel == chan_cfg_pkg::PTR_DEVICE |=>
		fc_out == $past(device_space_qualifier))
		else $error("qualifier does not follow device pointer");
	am_code_form_a: assert property (
		am_code[2:0] == fc_out && am_code[5:3] == jumpers)
		else $error("address modifier mis-formed");
	priv_select_a: assert property (
		ptr_drive && ptr_sel == chan_cfg_pkg::PTR_MEMORY |=>
		supervisor_cycle == $past(memory_space_qualifier[2]))
		else $error("privilege does not follow memory qualifier");
	width_select_a: assert property (
		ptr_drive && ptr_sel == chan_cfg_pkg::PTR_RELOAD |=>
		std24_cycle == $past(reload_space_qualifier[1]))
		else $error("width does not follow reload qualifier");
	space_select_a: assert property (
		program_space == fc_out[0])
		else $error("space select wrong");
	refuse_start_a: assert property (
		start_req && config_error && state == chan_cfg_pkg::ST_IDLE |=>
		start_refused && state == chan_cfg_pkg::ST_IDLE)
		else $error("start not refused on reserved code");
	chain_fetch_a: assert property (
		start_ok && chained |=> fetch_req && !xfer_active)
		else $error("chained start skipped table fetch");
	start_pulse_a: assert property (
		start_ok && peripheral_line_function == chan_cfg_pkg::PLF_START_OUT
		|=> !periph_out_n ##1 periph_out_n)
		else $error("start pulse wrong");
	line_state_a: assert property (
		pl_status ##1 pl_status |-> peripheral_line_state == $past(line_level_n))
		else $error("line state not reflected");
	flyby_kind_a: assert property (
		device_kind_select == 2'h2 |-> flyby_mode)
		else $error("ack device not flyby");

endmodule // dma_channel_config_regs

// ### engine_model.sv
// Far-side model of the transfer engine: answers table fetches and drains
// the channel FIFO into a small capture array.
// Assumes the channel clock and active-low reset; the bench drives stall.
`timescale 1ns/1ps

// ==========================================================================
// Engine model
module engine_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic slow,
	input wire logic stall,
	input wire logic fetch_req,
	output logic fetch_done,
	input wire logic mem_valid,
	output logic mem_ready,
	input wire logic [15:0] mem_data
);
	logic [3:0] wait_cnt;
	logic [15:0] got [0:15];
	int n_got;
	wire [3:0] fetch_delay = slow ? 4'h5 : 4'h1;

	assign mem_ready = !stall;

	// The table read is answered once per request; the done pulse itself
	// masks the request so one fetch never earns two answers.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wait_cnt <= 4'h0;
			fetch_done <= 1'b0;
			n_got <= 0;
		end else begin
			fetch_done <= 1'b0;
			if (fetch_req && !fetch_done) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt == fetch_delay) begin
					fetch_done <= 1'b1;
					wait_cnt <= 4'h0;
				end
			end
			if (mem_valid && mem_ready) begin
				got[n_got[3:0]] <= mem_data;
				n_got <= n_got + 1;
			end
		end
	end
endmodule // engine_model

// ### test_dma_channel_config_regs.sv
// Self-checking bench for the channel configuration block.
// Assumes engine_model answers fetches and drains the FIFO.
`timescale 1ns/1ps
`include "chan_cfg_consts.svh"

module test_dma_channel_config_regs;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [2:0] jumper_pins = 3'h0;
	logic ptr_drive = 1'b0;
	logic [1:0] ptr_sel = 2'h3;
	logic periph_in_n = 1'b1;
	logic ext_req_n = 1'b1;
	logic start_req = 1'b0;
	logic xfer_done = 1'b0;
	logic dev_valid = 1'b0;
	logic [15:0] dev_data = 16'h0000;
	logic stall = 1'b0;
	logic slow = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	wire [7:0] reg_rdata;
	wire [5:0] am_code;
	wire [2:0] fc_out;
	wire [15:0] mem_data;
	wire [1:0] external_request_mode, device_kind_select, operand_size;
	wire [1:0] peripheral_line_function, chain_mode, request_generation;
	wire reg_rvalid, supervisor_cycle, std24_cycle, program_space;
	wire device_port_width, xfer_dir_to_mem, flyby_mode, periph_out_n;
	wire periph_oe_n, peripheral_line_state, periph_irq, periph_abort;
	wire start_refused, config_error, fetch_req, fetch_done, xfer_active;
	wire operand_req, dev_ready, mem_valid, mem_ready;

	dma_channel_config_regs u_dut (.clock(clock), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.jumper_pins(jumper_pins), .ptr_drive(ptr_drive),
		.ptr_sel(ptr_sel), .fc_out(fc_out), .am_code(am_code),
		.supervisor_cycle(supervisor_cycle), .std24_cycle(std24_cycle),
		.program_space(program_space),
		.external_request_mode(external_request_mode),
		.device_kind_select(device_kind_select),
		.device_port_width(device_port_width),
		.peripheral_line_function(peripheral_line_function),
		.xfer_dir_to_mem(xfer_dir_to_mem), .operand_size(operand_size),
		.chain_mode(chain_mode), .request_generation(request_generation),
		.flyby_mode(flyby_mode), .periph_in_n(periph_in_n),
		.periph_out_n(periph_out_n), .periph_oe_n(periph_oe_n),
		.peripheral_line_state(peripheral_line_state),
		.periph_irq(periph_irq), .periph_abort(periph_abort),
		.ext_req_n(ext_req_n), .start_req(start_req),
		.start_refused(start_refused), .config_error(config_error),
		.fetch_req(fetch_req), .fetch_done(fetch_done),
		.xfer_active(xfer_active), .xfer_done(xfer_done),
		.operand_req(operand_req), .dev_valid(dev_valid),
		.dev_ready(dev_ready), .dev_data(dev_data), .mem_valid(mem_valid),
		.mem_ready(mem_ready), .mem_data(mem_data));

	engine_model u_eng (.clock(clock), .nrst(nrst), .slow(slow),
		.stall(stall), .fetch_req(fetch_req), .fetch_done(fetch_done),
		.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data));

	always #2 clock = ~clock;

	// ======================================================================
	// Shared tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hang would otherwise leave the run without a verdict.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clock);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clock);
		reg_re <= 1'b0;
		@(negedge clock);
		chk(reg_rvalid, 1'b1, "read valid");
		d = reg_rdata;
	endtask

	task automatic start_pulse();
		@(posedge clock);
		start_req <= 1'b1;
		@(posedge clock);
		start_req <= 1'b0;
		@(negedge clock);
	endtask

	task automatic set_line(input logic v);
		@(posedge clock);
		periph_in_n <= v;
	endtask

	// ======================================================================
	// Scenarios
	task automatic test_fields();
		logic [7:0] d;
		logic [1:0] k;
		logic [7:0] ofs [5] = '{`DEV_CTRL_OFS, `OP_CTRL_OFS, `MEM_QUAL_OFS,
			`DEV_QUAL_OFS, `RELOAD_QUAL_OFS};
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], d);
			chk(d, 8'h00, "reset value");
		end
		rd(8'h07, d);
		chk(d, 8'h00, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			wr(`DEV_CTRL_OFS, {k, k, k[0], 1'b0, k});
			wr(`OP_CTRL_OFS, {k[0], 1'b0, k, k, k});
			@(negedge clock);
			chk(external_request_mode, k, "request mode");
			chk(device_kind_select, k, "device kind");
			chk(flyby_mode, k[1], "flyby");
			chk(device_port_width, k[0], "port width");
			chk(peripheral_line_function, k, "line function");
			chk(xfer_dir_to_mem, k[0], "direction");
			chk(operand_size, k, "operand size");
			chk(chain_mode, k, "chain");
			chk(request_generation, k, "request gen");
			chk(config_error, k[0], "reserved code");
			rd(`OP_CTRL_OFS, d);
			chk(d, {k[0], 1'b0, k, k, k}, "readback");
		end
		$display("fields test done");
	endtask

	task automatic test_qual();
		logic [7:0] d;
		logic [2:0] q [3] = '{3'h5, 3'h2, 3'h7};
		logic [7:0] ofs [3] = '{`MEM_QUAL_OFS, `DEV_QUAL_OFS,
			`RELOAD_QUAL_OFS};
		jumper_pins <= 3'h6;
		for (int i = 0; i < 3; i++)
			wr(ofs[i], {5'h1f, q[i]});
		for (int i = 0; i < 3; i++) begin
			rd(ofs[i], d);
			chk(d, {5'h00, q[i]}, "qualifier read");
			@(posedge clock);
			ptr_drive <= 1'b1;
			ptr_sel <= i[1:0];
			repeat (2) @(posedge clock);
			@(negedge clock);
			chk(fc_out, q[i], "pointer qualifier");
			chk(am_code, {3'h6, q[i]}, "modifier");
			chk(supervisor_cycle, q[i][2], "privilege");
			chk(std24_cycle, q[i][1], "width");
			chk(program_space, q[i][0], "space");
		end
		@(posedge clock);
		ptr_drive <= 1'b0;
		ptr_sel <= 2'h1;
		repeat (3) @(negedge clock);
		chk(fc_out, q[2], "qualifier held");
		$display("qualifier test done");
	endtask

	task automatic test_chain();
		wr(`DEV_CTRL_OFS, 8'ha2);
		wr(`OP_CTRL_OFS, 8'h8a);
		stall <= 1'b1;
		slow <= 1'b1;
		start_pulse();
		chk(fetch_req, 1'b1, "table fetch first");
		chk(xfer_active, 1'b0, "no early transfer");
		chk(periph_out_n, 1'b0, "start pulse");
		chk(periph_oe_n, 1'b0, "line driven");
		@(negedge clock);
		chk(periph_out_n, 1'b1, "pulse width");
		for (int n = 0; n < 20 && xfer_active !== 1'b1; n++)
			@(negedge clock);
		chk(xfer_active, 1'b1, "transfer after fetch");
		chk(operand_req, 1'b0, "waits for request line");
		@(posedge clock);
		ext_req_n <= 1'b0;
		repeat (6) @(negedge clock);
		chk(operand_req, 1'b1, "request line honoured");
		@(posedge clock);
		ext_req_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			@(posedge clock);
			dev_valid <= 1'b1;
			dev_data <= 16'h5a00 + 16'(i);
			@(negedge clock);
			chk(dev_ready, 16'(i < 8), "fifo space");
		end
		@(posedge clock);
		dev_valid <= 1'b0;
		stall <= 1'b0;
		repeat (12) @(negedge clock);
		chk(16'(u_eng.n_got), 16'h0008, "drained count");
		for (int i = 0; i < 8; i++)
			chk(u_eng.got[i], 16'h5a00 + 16'(i), "drain order");
		chk(mem_valid, 1'b0, "fifo empty");
		@(posedge clock);
		xfer_done <= 1'b1;
		@(posedge clock);
		xfer_done <= 1'b0;
		@(negedge clock);
		chk(xfer_active, 1'b0, "transfer ended");
		$display("chain test done");
	endtask

	task automatic test_refuse();
		logic [15:0] cfg [3] = '{16'h4000, 16'h0030, 16'h0004};
		for (int i = 0; i < 3; i++) begin
			wr(`DEV_CTRL_OFS, cfg[i][15:8]);
			wr(`OP_CTRL_OFS, cfg[i][7:0]);
			start_pulse();
			chk(start_refused, 1'b1, "refused");
			chk(xfer_active | fetch_req, 1'b0, "not started");
			@(negedge clock);
			chk(start_refused, 1'b0, "refusal pulse");
		end
		$display("refusal test done");
	endtask

	task automatic test_line();
		int seen = 0;
		wr(`DEV_CTRL_OFS, 8'h00);
		set_line(1'b0);
		repeat (6) @(negedge clock);
		chk(peripheral_line_state, 1'b0, "line low");
		chk(periph_oe_n, 1'b1, "line is input");
		set_line(1'b1);
		repeat (6) @(negedge clock);
		chk(peripheral_line_state, 1'b1, "line high");
		wr(`DEV_CTRL_OFS, 8'h01);
		set_line(1'b0);
		repeat (8) begin
			@(negedge clock);
			seen += int'(periph_irq === 1'b1);
		end
		chk(16'(seen), 16'h0001, "one interrupt");
		set_line(1'b1);
		wr(`DEV_CTRL_OFS, 8'h03);
		wr(`OP_CTRL_OFS, 8'h00);
		repeat (6) @(negedge clock);
		start_pulse();
		chk(xfer_active, 1'b1, "unchained start");
		chk(operand_req, 1'b1, "automatic request");
		set_line(1'b0);
		seen = 0;
		repeat (8) begin
			@(negedge clock);
			seen += int'(periph_abort === 1'b1);
		end
		chk(16'(seen), 16'h0001, "abort pulse");
		chk(xfer_active, 1'b0, "aborted");
		set_line(1'b1);
		$display("line test done");
	endtask

	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		test_fields();
		test_qual();
		test_refuse();
		test_chain();
		test_line();
		conclude();
	end
endmodule // test_dma_channel_config_regs
